// ===== hw/sprw_pkg.sv
// package for the strobe processor register/wait execution block
// assumes one 200 MHz clock and a 32-bit Avalon-MM register bus
`default_nettype none
package sprw_pkg;
  localparam int unsigned CLK_MHZ        = 200;
  localparam logic [3:0]  RAND_REUSE_CYC = 4'hD;   // 13 clocks
  localparam int unsigned PROG_DEPTH     = 32;
  // register byte offsets
  localparam logic [7:0]  OFS_CTRL  = 8'h00;
  localparam logic [7:0]  OFS_STAT  = 8'h04;
  localparam logic [7:0]  OFS_LEN   = 8'h08;
  localparam logic [7:0]  OFS_SCR_A = 8'h0C;
  localparam logic [7:0]  OFS_SCR_B = 8'h10;
  localparam logic [7:0]  OFS_SCR_C = 8'h14;
  localparam logic [7:0]  OFS_SCR_D = 8'h18;
  localparam logic [7:0]  OFS_ISTAT = 8'h1C;
  localparam logic [7:0]  OFS_IMASK = 8'h20;
  localparam int unsigned PROG_SEL_BIT = 7;        // 0x80..0xFC program words
  // field positions
  localparam int unsigned CTRL_START = 0;
  localparam int unsigned CTRL_HALT  = 1;
  localparam int unsigned STAT_RUN   = 0;
  localparam int unsigned STAT_PC_LO = 8;
  localparam int unsigned IRQ_SW     = 0;
  localparam int unsigned IRQ_REGW   = 1;
  localparam int unsigned IRQ_FIXW   = 2;
  localparam logic [5:0]  LEN_RST    = 6'h00;
  localparam logic [2:0]  IMASK_RST  = 3'h0;
  // opcodes
  localparam logic [7:0] OP_INC_A = 8'hC0;
  localparam logic [7:0] OP_INC_B = 8'hC1;
  localparam logic [7:0] OP_INC_C = 8'hC2;
  localparam logic [7:0] OP_DEC_A = 8'hC3;
  localparam logic [7:0] OP_DEC_B = 8'hC4;
  localparam logic [7:0] OP_DEC_C = 8'hC5;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01, ST_EXEC = 5'h02, ST_REGISTER_COUNT_WAIT_OP = 5'h04, ST_WAITW = 5'h08, ST_WEVT = 5'h10
  } sprw_state_t;

  typedef enum logic [4:0] {
    OC_SKIP, OC_WAITW, OC_RPT, OC_WEVT1, OC_WEVT2, OC_INT, OC_LABEL, OC_REGISTER_COUNT_WAIT_OP,
    OC_RAND, OC_SETCMP, OC_INC_A, OC_INC_B, OC_INC_C, OC_DEC_A, OC_DEC_B,
    OC_DEC_C, OC_CAPINC, OC_STROBE, OC_ISTROBE, OC_ICLEAR
  } sprw_opclass_t;

  typedef struct packed {
    logic       overflow;
    logic       compare_event;
    logic [7:0] random_source_word;
  } sprw_tmr_in_t;

  // twenty base types; both strobe kinds take 16 sub-ops in bits 3:0
  function automatic sprw_opclass_t sprw_decode(input logic [7:0] op);
    sprw_opclass_t c;
    c = OC_SKIP;
    if (op[7:5] == 3'h4)               c = OC_WAITW;
    else if (op[7:4] == 4'hA)          c = OC_RPT;
    else if (op[7:4] == 4'hD)          c = OC_STROBE;
    else if (op == 8'hFF)              c = OC_ICLEAR;
    else if (op[7:4] == 4'hE)          c = OC_ISTROBE;
    else if (op[7:3] == 5'h19)         c = OC_CAPINC;
    else if (op[7:3] == 5'h18) begin
      case (op[2:0])
        3'h0: c = OC_INC_A;
        3'h1: c = OC_INC_B;
        3'h2: c = OC_INC_C;
        3'h3: c = OC_DEC_A;
        3'h4: c = OC_DEC_B;
        3'h5: c = OC_DEC_C;
        default: c = OC_SKIP;
      endcase
    end else if (op[7:3] == 5'h17) begin
      case (op[2:0])
        3'h0: c = OC_WEVT1;
        3'h1: c = OC_WEVT2;
        3'h2: c = OC_INT;
        3'h3: c = OC_LABEL;
        3'h4: c = OC_REGISTER_COUNT_WAIT_OP;
        3'h5: c = OC_RAND;
        3'h6: c = OC_SETCMP;
        default: c = OC_SKIP;
      endcase
    end
    return c;
  endfunction

  function automatic logic [7:0] sprw_capped_inc(input logic [7:0] y, input logic [2:0] m);
    logic [7:0] inc;
    inc = y + 8'h01;
    return (inc < {5'h00, m}) ? inc : {5'h00, m};
  endfunction

  function automatic logic [7:0] sprw_rand_fill(input logic [7:0] rv, input logic [7:0] y);
    logic [7:0] msk;
    msk = (8'h01 << y[2:0]) - 8'h01;
    return (y == 8'h00 || y > 8'h07) ? rv : (rv & msk);
  endfunction

  function automatic logic [5:0] sprw_wait_target(input logic [4:0] w);
    return (w == 5'h00) ? 6'h20 : {1'b0, w};
  endfunction
endpackage
`default_nettype wire

// ===== hw/sprw_top.sv
// execution of scratch register ops and timer waits for the strobe processor
// assumes timer and random inputs synchronous to mclk; program loaded over Avalon-MM
//
// The implementer's own choices: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - decode twenty base types; strobe and immediate strobe carry sixteen sub-ops.
// - operands are own program counter and four scratch registers A to D.
// - 0xC5, 0xC4, 0xC3 decrement C, B, A; zero wraps to 0xFF.
// - 0xC0, 0xC1, 0xC2 increment A, B, C; 0xFF wraps to zero.
// - capped increment sets B to min(B+1, three-bit limit).
// - 0xBD loads low B bits of A randomly; B zero or above 7 loads all.
// - random load within 13 clocks of the last reuses the same value.
// - software interrupt op raises the general interrupt request.
// - 0xBC holds while A nonzero, decrements A per overflow; none if A zero.
// - register-count wait raises its interrupt when execution resumes.
// - register-count wait tests live A, so changes alter the wait.
// - 0xBE pulses the compare load output to the timer.
// - 0x80-0x9F wait for W overflows; W zero means thirty-two.
// - fixed wait done advances and asserts fixed-wait interrupt flag.
// - 0xB8 holds until timer compare event, then advances.
module sprw_top (
  // clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  // avalon-mm slave
  input  wire logic [7:0]            avs_address,
  input  wire logic                  avs_read,
  input  wire logic                  avs_write,
  input  wire logic [31:0]           avs_writedata,
  output logic      [31:0]           avs_readdata,
  output logic                       avs_waitrequest,
  // mac timer and random source
  input  wire sprw_pkg::sprw_tmr_in_t tmr,
  output logic                       timer_compare_load_pulse,
  output logic                       seq_fixed_wait_irq,
  // interrupt
  output logic                       irq
);
  import sprw_pkg::*;

  typedef struct packed {
    sprw_state_t st;
    logic [5:0]  pc;
    logic [5:0]  len;
    logic [7:0]  scratch_reg_a;
    logic [7:0]  scratch_reg_b;
    logic [7:0]  scratch_reg_c;
    logic [7:0]  scratch_reg_d;
    logic [5:0]  wcnt;
    logic [7:0]  rnd_hold;
    logic [3:0]  rnd_age;
    logic [2:0]  irq_stat;
    logic [2:0]  irq_mask;
    logic        irq;
    logic        cmp_pulse;
    logic        fixed_pulse;
    logic        waitreq;
    logic [31:0] rdata;
  } sprw_regs_t;

  sprw_regs_t    s;
  sprw_regs_t    n;
  logic [7:0]    prog_mem [PROG_DEPTH];
  logic [7:0]    instr;
  sprw_opclass_t oc;
  logic          exec_now;
  logic          wr_any;
  logic [2:0]    ev;
  logic [5:0]    cnt_nx;
  logic [7:0]    rv;
  logic          adv;

  assign instr    = prog_mem[s.pc[4:0]];
  assign oc       = sprw_decode(instr);
  assign exec_now = (s.st == ST_EXEC) && (s.pc < s.len);
  assign wr_any   = avs_write && !s.waitreq;

  always_ff @(posedge mclk) begin
    if (wr_any && avs_address[PROG_SEL_BIT]) begin
      prog_mem[avs_address[6:2]] <= avs_writedata[7:0];
    end
  end

  always_comb begin
    n             = s;
    ev            = 3'h0;
    adv           = 1'b0;
    rv            = 8'h00;
    cnt_nx        = s.wcnt + {5'h00, tmr.overflow};
    n.cmp_pulse   = 1'b0;
    n.fixed_pulse = 1'b0;
    n.waitreq     = 1'b1;
    if (s.rnd_age != RAND_REUSE_CYC) begin
      n.rnd_age = s.rnd_age + 4'h1;
    end
    case (s.st)
      ST_IDLE: begin
      end
      ST_EXEC: begin
        if (!exec_now) begin
          n.st = ST_IDLE;
        end else begin
          adv = 1'b1;
          // 8-bit wrap on all scratch arithmetic
          case (oc)
            OC_INC_A: n.scratch_reg_a = s.scratch_reg_a + 8'h01;
            OC_INC_B: n.scratch_reg_b = s.scratch_reg_b + 8'h01;
            OC_INC_C: n.scratch_reg_c = s.scratch_reg_c + 8'h01;
            OC_DEC_A: n.scratch_reg_a = s.scratch_reg_a - 8'h01;
            OC_DEC_B: n.scratch_reg_b = s.scratch_reg_b - 8'h01;
            OC_DEC_C: n.scratch_reg_c = s.scratch_reg_c - 8'h01;
            OC_CAPINC: n.scratch_reg_b = sprw_capped_inc(s.scratch_reg_b, instr[2:0]);
            OC_RAND: begin
              // recent load reuses held value
              rv = (s.rnd_age < RAND_REUSE_CYC) ? s.rnd_hold : tmr.random_source_word;
              n.rnd_hold      = rv;
              n.rnd_age       = 4'h0;
              n.scratch_reg_a = sprw_rand_fill(rv, s.scratch_reg_b);
            end
            OC_INT: ev[IRQ_SW] = 1'b1;
            OC_SETCMP: n.cmp_pulse = 1'b1;
            OC_REGISTER_COUNT_WAIT_OP: begin
              if (s.scratch_reg_a != 8'h00) begin
                adv  = 1'b0;
                n.st = ST_REGISTER_COUNT_WAIT_OP;
              end else begin
                ev[IRQ_REGW] = 1'b1;
              end
            end
            OC_WAITW: begin
              adv    = 1'b0;
              n.st   = ST_WAITW;
              n.wcnt = 6'h00;
            end
            OC_WEVT1: begin
              adv  = 1'b0;
              n.st = ST_WEVT;
            end
            // other types run in the neighbouring logic
            default: begin
            end
          endcase
        end
      end
      ST_REGISTER_COUNT_WAIT_OP: begin
        // live register tested every cycle
        if (s.scratch_reg_a == 8'h00) begin
          adv          = 1'b1;
          n.st         = ST_EXEC;
          ev[IRQ_REGW] = 1'b1;
        end else if (tmr.overflow) begin
          n.scratch_reg_a = s.scratch_reg_a - 8'h01;
        end
      end
      ST_WAITW: begin
        if (cnt_nx == sprw_wait_target(instr[4:0])) begin
          adv           = 1'b1;
          n.st          = ST_EXEC;
          n.fixed_pulse = 1'b1;
          ev[IRQ_FIXW]  = 1'b1;
        end else begin
          n.wcnt = cnt_nx;
        end
      end
      ST_WEVT: begin
        if (tmr.compare_event) begin
          adv  = 1'b1;
          n.st = ST_EXEC;
        end
      end
      default: n.st = ST_IDLE;
    endcase
    if (adv) begin
      n.pc = s.pc + 6'h01;
    end
    // bus access: answer one cycle after the request is seen
    if ((avs_read || avs_write) && s.waitreq) begin
      n.waitreq = 1'b0;
      n.rdata   = 32'h0;
      if (avs_address[PROG_SEL_BIT]) begin
        n.rdata[7:0] = prog_mem[avs_address[6:2]];
      end else begin
        case ({avs_address[7:2], 2'b00})
          OFS_STAT: begin
            n.rdata[STAT_RUN]                 = (s.st != ST_IDLE);
            n.rdata[STAT_PC_LO +: 6]          = s.pc;
          end
          OFS_LEN:   n.rdata[5:0] = s.len;
          OFS_SCR_A: n.rdata[7:0] = s.scratch_reg_a;
          OFS_SCR_B: n.rdata[7:0] = s.scratch_reg_b;
          OFS_SCR_C: n.rdata[7:0] = s.scratch_reg_c;
          OFS_SCR_D: n.rdata[7:0] = s.scratch_reg_d;
          OFS_ISTAT: n.rdata[2:0] = s.irq_stat;
          OFS_IMASK: n.rdata[2:0] = s.irq_mask;
          default:   n.rdata      = 32'h0;
        endcase
      end
    end
    // software writes land after execution, so they win over everything but interrupt flag sets
    n.irq_stat = s.irq_stat;
    if (wr_any && !avs_address[PROG_SEL_BIT]) begin
      case ({avs_address[7:2], 2'b00})
        OFS_CTRL: begin
          if (avs_writedata[CTRL_START]) begin
            n.pc = 6'h00;
            n.st = ST_EXEC;
          end
          if (avs_writedata[CTRL_HALT]) begin
            n.st = ST_IDLE;
          end
        end
        OFS_LEN:   n.len           = avs_writedata[5:0];
        OFS_SCR_A: n.scratch_reg_a = avs_writedata[7:0];
        OFS_SCR_B: n.scratch_reg_b = avs_writedata[7:0];
        OFS_SCR_C: n.scratch_reg_c = avs_writedata[7:0];
        OFS_SCR_D: n.scratch_reg_d = avs_writedata[7:0];
        OFS_ISTAT: n.irq_stat      = s.irq_stat & ~avs_writedata[2:0];
        OFS_IMASK: n.irq_mask      = avs_writedata[2:0];
        default: begin
        end
      endcase
    end
    // set wins over write-one-to-clear
    n.irq_stat = n.irq_stat | ev;
    n.irq      = |(n.irq_stat & n.irq_mask);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.st       <= ST_IDLE;
      s.len      <= LEN_RST;
      s.irq_mask <= IMASK_RST;
      s.rnd_age  <= RAND_REUSE_CYC;
      s.waitreq  <= 1'b1;
    end else begin
      s <= n;
    end
  end

  assign avs_readdata             = s.rdata;
  assign avs_waitrequest          = s.waitreq;
  assign timer_compare_load_pulse = s.cmp_pulse;
  assign seq_fixed_wait_irq       = s.fixed_pulse;
  assign irq                      = s.irq;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  property p_dec;
    exec_now && instr == OP_DEC_A && !wr_any |=> s.scratch_reg_a == $past(s.scratch_reg_a) - 8'h01;
  endproperty
  a_dec: assert property (p_dec) else $error("decrement wrong");

  property p_inc;
    exec_now && instr == OP_INC_C && !wr_any |=> s.scratch_reg_c == $past(s.scratch_reg_c) + 8'h01;
  endproperty
  a_inc: assert property (p_inc) else $error("increment wrong");

  property p_cap;
    exec_now && oc == OC_CAPINC && !wr_any
      |=> s.scratch_reg_b == (($past(s.scratch_reg_b) + 8'h01 < {5'h00, $past(instr[2:0])})
        ? $past(s.scratch_reg_b) + 8'h01 : {5'h00, $past(instr[2:0])});
  endproperty
  a_cap: assert property (p_cap) else $error("capped increment wrong");

  property p_rand;
    exec_now && oc == OC_RAND && s.rnd_age == RAND_REUSE_CYC && s.scratch_reg_b == 8'h00 && !wr_any
      |=> s.scratch_reg_a == $past(tmr.random_source_word);
  endproperty
  a_rand: assert property (p_rand) else $error("random load wrong");

  property p_reuse;
    exec_now && oc == OC_RAND && s.rnd_age < RAND_REUSE_CYC && !wr_any
      |=> s.scratch_reg_a == sprw_rand_fill($past(s.rnd_hold), $past(s.scratch_reg_b));
  endproperty
  a_reuse: assert property (p_reuse) else $error("random value not reused");

  property p_swint;
    exec_now && oc == OC_INT |=> s.irq_stat[IRQ_SW];
  endproperty
  a_swint: assert property (p_swint) else $error("software interrupt missing");

  property p_waitx0;
    exec_now && oc == OC_REGISTER_COUNT_WAIT_OP && s.scratch_reg_a == 8'h00 && !wr_any
      |=> s.st == ST_EXEC && s.pc == $past(s.pc) + 6'h01;
  endproperty
  a_waitx0: assert property (p_waitx0) else $error("zero count wait stalled");

  property p_regw;
    s.st == ST_REGISTER_COUNT_WAIT_OP && s.scratch_reg_a == 8'h00 |=> s.irq_stat[IRQ_REGW];
  endproperty
  a_regw: assert property (p_regw) else $error("register wait interrupt missing");

  property p_live;
    s.st == ST_REGISTER_COUNT_WAIT_OP && s.scratch_reg_a != 8'h00 && tmr.overflow && !wr_any
      |=> s.scratch_reg_a == $past(s.scratch_reg_a) - 8'h01 && s.st == ST_REGISTER_COUNT_WAIT_OP;
  endproperty
  a_live: assert property (p_live) else $error("overflow not counted down");

  property p_cmp;
    s.cmp_pulse |-> $past(exec_now) && $past(oc) == OC_SETCMP;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare load pulse without op");

  property p_wcnt;
    s.st == ST_WAITW |-> s.wcnt < sprw_wait_target(instr[4:0]);
  endproperty
  a_wcnt: assert property (p_wcnt) else $error("overflow count beyond target");

  property p_fix;
    s.st == ST_WAITW && cnt_nx == sprw_wait_target(instr[4:0]) && !wr_any
      |=> seq_fixed_wait_irq && s.st == ST_EXEC ##1 !seq_fixed_wait_irq;
  endproperty
  a_fix: assert property (p_fix) else $error("fixed wait end wrong");

  property p_evt;
    s.st == ST_WEVT && tmr.compare_event && !wr_any |=> s.st == ST_EXEC && s.pc == $past(s.pc) + 6'h01;
  endproperty
  a_evt: assert property (p_evt) else $error("event wait did not advance");

  property p_entry;
    exec_now && oc == OC_WAITW && !wr_any |=> s.st == ST_WAITW && s.wcnt == 6'h00;
  endproperty
  a_entry: assert property (p_entry) else $error("overflow count not cleared");

  property p_dec_b;
    exec_now && instr == OP_DEC_B && !wr_any
      |=> s.scratch_reg_b == $past(s.scratch_reg_b) - 8'h01;
  endproperty
  a_dec_b: assert property (p_dec_b) else $error("decrement of b wrong");

  property p_dec_c;
    exec_now && instr == OP_DEC_C && !wr_any
      |=> s.scratch_reg_c == $past(s.scratch_reg_c) - 8'h01;
  endproperty
  a_dec_c: assert property (p_dec_c) else $error("decrement of c wrong");

  property p_inc_a;
    exec_now && instr == OP_INC_A && !wr_any
      |=> s.scratch_reg_a == $past(s.scratch_reg_a) + 8'h01;
  endproperty
  a_inc_a: assert property (p_inc_a) else $error("increment of a wrong");

  property p_inc_b;
    exec_now && instr == OP_INC_B && !wr_any
      |=> s.scratch_reg_b == $past(s.scratch_reg_b) + 8'h01;
  endproperty
  a_inc_b: assert property (p_inc_b) else $error("increment of b wrong");

  property p_rand_mask;
    exec_now && oc == OC_RAND && s.scratch_reg_b != 8'h00 && s.scratch_reg_b < 8'h08 && !wr_any
      |=> (s.scratch_reg_a >> $past(s.scratch_reg_b)) == 8'h00;
  endproperty
  a_rand_mask: assert property (p_rand_mask) else $error("random upper bits not cleared");

  property p_register_count_wait_op_hold;
    s.st == ST_REGISTER_COUNT_WAIT_OP && s.scratch_reg_a != 8'h00 && !wr_any
      |=> s.pc == $past(s.pc);
  endproperty
  a_register_count_wait_op_hold: assert property (p_register_count_wait_op_hold) else $error("register wait did not hold");

  property p_setcmp;
    exec_now && oc == OC_SETCMP
      |=> timer_compare_load_pulse;
  endproperty
  a_setcmp: assert property (p_setcmp) else $error("compare load pulse missing");

  property p_wevt_hold;
    s.st == ST_WEVT && !tmr.compare_event && !wr_any
      |=> s.st == ST_WEVT && $stable(s.pc);
  endproperty
  a_wevt_hold: assert property (p_wevt_hold) else $error("event wait did not hold");

  property p_wcnt_hold;
    s.st == ST_WAITW && !tmr.overflow && !wr_any
      |=> s.st == ST_WAITW && $stable(s.wcnt);
  endproperty
  a_wcnt_hold: assert property (p_wcnt_hold) else $error("count moved without overflow");
endmodule // sprw_top
`default_nettype wire

// ===== test/sprw_tmr_model.sv
// mac timer and random source model facing sprw_top
// assumes bench commands change right after a rising mclk edge
`timescale 1ns/10ps
`default_nettype none
module sprw_tmr_model (
  // clock and reset
  input  wire logic                   mclk,
  input  wire logic                   rst_n,
  // bench commands
  input  wire logic                   ovf_go,
  input  wire logic [5:0]             ovf_n,
  input  wire logic                   cmp_go,
  input  wire logic [7:0]             word_set,
  output logic                        busy,
  output logic [7:0]                  loads,
  // block side
  input  wire logic                   timer_compare_load_pulse,
  output var sprw_pkg::sprw_tmr_in_t  tmr
);
  import sprw_pkg::*;
  logic [5:0] left_q;
  logic [1:0] gap_q;
  assign busy = (left_q != 6'h00) || ovf_go;
  // overflows one cycle wide, four cycles apart
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 6'h00;
      gap_q <= 2'h0;
      tmr <= '0;
      loads <= 8'h00;
    end else begin
      tmr.overflow <= 1'b0;
      tmr.compare_event <= cmp_go;
      tmr.random_source_word <= word_set;
      if (timer_compare_load_pulse) begin
        loads <= loads + 8'h01;
      end
      if (ovf_go) begin
        left_q <= ovf_n;
        gap_q <= 2'h0;
      end else if (left_q != 6'h00) begin
        gap_q <= gap_q + 2'h1;
        if (gap_q == 2'h3) begin
          tmr.overflow <= 1'b1;
          left_q <= left_q - 6'h01;
        end
      end
    end
  end
endmodule // sprw_tmr_model
`default_nettype wire

// ===== test/strobe_processor_reg_wait_ops_tb.sv
// self-checking bench for sprw_top
// assumes sprw_tmr_model on the timer side
`timescale 1ns/10ps
`default_nettype none
module strobe_processor_reg_wait_ops_tb;
  import sprw_pkg::*;
  logic         mclk, rst_n, rd, wr, wreq, ogo, cgo, busy, cpl, fwi, irq;
  logic [7:0]   adr, wset, loads;
  logic [31:0]  wd, rdat, q;
  logic [5:0]   on;
  sprw_tmr_in_t tmr;
  int           fails, compares, cyc, fw;

  sprw_top i_dut (.mclk(mclk), .rst_n(rst_n), .avs_address(adr), .avs_read(rd),
    .avs_write(wr), .avs_writedata(wd), .avs_readdata(rdat), .avs_waitrequest(wreq),
    .tmr(tmr), .timer_compare_load_pulse(cpl), .seq_fixed_wait_irq(fwi), .irq(irq));
  sprw_tmr_model i_tmr (.mclk(mclk), .rst_n(rst_n), .ovf_go(ogo), .ovf_n(on),
    .cmp_go(cgo), .word_set(wset), .busy(busy), .loads(loads),
    .timer_compare_load_pulse(cpl), .tmr(tmr));

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    cyc++;
    if (fwi === 1'b1) fw++;
    if (cyc == 20000) begin
      fails++;
      report_and_stop;
    end
  end

  task automatic report_and_stop;
    if (fails == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one avalon access; holds until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wreq !== 1'b0 && n < 40);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 40) chk(32'h0, 32'h1);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task automatic start(input logic [7:0] p[$]);
    foreach (p[i]) bus(1'b1, 8'(8'h80 + 4 * i), {24'h0, p[i]});
    bus(1'b1, OFS_LEN, 32'(p.size()));
    bus(1'b1, OFS_CTRL, 32'h1);
  endtask
  task automatic idle;
    int n;
    n = 0;
    do begin
      bus(1'b0, OFS_STAT, 32'h0);
      n++;
    end while (q[STAT_RUN] !== 1'b0 && n < 100);
    chk({31'h0, q[STAT_RUN]}, 32'h0);
  endtask
  task automatic fire(input logic [5:0] n);
    int k;
    @(posedge mclk);
    ogo <= 1'b1;
    on <= n;
    @(posedge mclk);
    ogo <= 1'b0;
    k = 0;
    while (busy && k < 400) begin
      @(posedge mclk);
      k++;
    end
  endtask

  task automatic t_arith;
    bus(1'b1, OFS_SCR_A, 32'hFF);
    bus(1'b1, OFS_SCR_B, 32'h00);
    bus(1'b1, OFS_SCR_C, 32'h7F);
    start('{8'hC0, 8'hC4, 8'hC2, 8'hC3, 8'hC3, 8'hC1, 8'hC1, 8'hC5, 8'hC5});
    idle;
    rdc(OFS_SCR_A, 32'hFE);
    rdc(OFS_SCR_B, 32'h01);
    rdc(OFS_SCR_C, 32'h7E);
  endtask
  task automatic t_cap;
    bus(1'b1, OFS_SCR_B, 32'h05);
    start('{8'hCF, 8'hCF, 8'hCF, 8'hCA});
    idle;
    rdc(OFS_SCR_B, 32'h02);
  endtask
  // second load waits on a compare event; word changes meanwhile
  task automatic t_rand(input logic [7:0] y, input int dly, input logic [31:0] exp);
    wset <= 8'hA5;
    repeat (20) @(posedge mclk);
    bus(1'b1, OFS_SCR_B, {24'h0, y});
    start('{8'hBD, 8'hB8, 8'hC1, 8'hBD});
    repeat (dly) @(posedge mclk);
    wset <= 8'h3C;
    @(posedge mclk);
    cgo <= 1'b1;
    @(posedge mclk);
    cgo <= 1'b0;
    idle;
    rdc(OFS_SCR_A, exp);
  endtask
  task automatic t_register_count_wait_op;
    bus(1'b1, OFS_SCR_A, 32'h03);
    bus(1'b1, OFS_SCR_B, 32'h00);
    start('{8'hBC, 8'hC1});
    bus(1'b1, OFS_SCR_A, 32'h01);
    fire(6'h01);
    idle;
    rdc(OFS_SCR_A, 32'h00);
    rdc(OFS_SCR_B, 32'h01);
    rdc(OFS_ISTAT, 32'h02);
    bus(1'b1, OFS_ISTAT, 32'h7);
    start('{8'hBC});
    idle;
    rdc(OFS_ISTAT, 32'h02);
    bus(1'b1, OFS_ISTAT, 32'h7);
    bus(1'b1, OFS_SCR_A, 32'h03);
    start('{8'hBC});
    bus(1'b1, OFS_CTRL, 32'h2);
    rdc(OFS_STAT, 32'h0);
    rdc(OFS_SCR_A, 32'h03);
  endtask
  task automatic t_waitw(input logic [7:0] op, input logic [5:0] n);
    int f0;
    f0 = fw;
    start('{op});
    fire(n - 6'h01);
    bus(1'b0, OFS_STAT, 32'h0);
    chk({31'h0, q[STAT_RUN]}, 32'h1);
    fire(6'h01);
    idle;
    chk(32'(fw - f0), 32'h1);
    rdc(OFS_ISTAT, 32'h04);
    bus(1'b1, OFS_ISTAT, 32'h7);
  endtask
  task automatic t_int;
    bus(1'b1, OFS_IMASK, 32'h0);
    start('{8'hBA});
    idle;
    rdc(OFS_ISTAT, 32'h01);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, OFS_IMASK, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    bus(1'b1, OFS_ISTAT, 32'h1);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    rdc(OFS_ISTAT, 32'h00);
    rdc(8'h40, 32'h0);
  endtask
  task automatic t_cmp;
    logic [7:0] l0;
    l0 = loads;
    start('{8'hBE, 8'hBF, 8'hBE});
    idle;
    chk({24'h0, loads - l0}, 32'h2);
  endtask

  initial begin
    rst_n = 1'b0;
    rd = 1'b0;
    wr = 1'b0;
    adr = 8'h00;
    wd = 32'h0;
    ogo = 1'b0;
    on = 6'h00;
    cgo = 1'b0;
    wset = 8'hA5;
    fails = 0;
    compares = 0;
    cyc = 0;
    fw = 0;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rdc(OFS_IMASK, 32'h0);
    rdc(OFS_SCR_A, 32'h0);
    t_arith;
    t_cap;
    t_rand(8'h03, 3, 32'h05);
    t_rand(8'h08, 20, 32'h3C);
    t_rand(8'h00, 20, 32'h00);
    t_register_count_wait_op;
    t_waitw(8'h82, 6'h02);
    t_waitw(8'h80, 6'h20);
    t_int;
    t_cmp;
    report_and_stop;
  end
endmodule // strobe_processor_reg_wait_ops_tb
`default_nettype wire
